//--- pps_pkg.sv
// Package of constants and types for the PHY power-state sequencer.
package pps_pkg;

  // ----------------------------------------------------------------
  // Register indices and address width
  // ----------------------------------------------------------------
  localparam logic [11:0] AUTONOMOUS_CONTROL_IDX   = 12'h18B;
  localparam logic [11:0] POWER_MODE_CONTROL_IDX   = 12'h18C;
  localparam logic [11:0] SLEEP_CODE_CONTROL_TWO_IDX = 12'h487;
  localparam logic [11:0] SLEEP_CODE_CONFIG_IDX    = 12'h4E5;
  localparam logic [11:0] STATE_STATUS_IDX         = 12'h4F0;
  localparam int          ADDR_W                   = 14;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int          AUTO_TX_EN_BIT    = 0;
  localparam int          AUTO_SLEEP_EN_BIT = 1;
  localparam int          POWER_MODE_CONTROL_NORMAL_BIT   = 0;
  localparam int          POWER_MODE_CONTROL_SLEEP_BIT    = 1;
  localparam int          CTRL2_RX_EN_BIT   = 0;
  localparam int          CFG_STREAM_LSB    = 8;
  localparam logic [15:0] AUTO_RESET        = 16'h0002;
  localparam logic [15:0] ZERO16            = 16'h0000;
  localparam logic [31:0] ZERO32            = 32'h0000_0000;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ            = 10_000_000;
  localparam int SLEEP_RQST_US     = 1000;
  localparam int SILENT_US         = 8000;
  localparam int SLEEP_RQST_CYCLES = SLEEP_RQST_US * (CLK_HZ / 1_000_000);
  localparam int SILENT_CYCLES     = SILENT_US * (CLK_HZ / 1_000_000);
  localparam int TMR_W             = 17;

  // ----------------------------------------------------------------
  // Power states
  // ----------------------------------------------------------------
  typedef enum logic [4:0] {
    ST_NORMAL  = 5'b00001,
    ST_SLP_REQ = 5'b00010,
    ST_SILENT  = 5'b00100,
    ST_STANDBY = 5'b01000,
    ST_SLEEP   = 5'b10000
  } pps_state_t;

endpackage : pps_pkg

//--- pps_sync.sv
// Two-flip-flop synchroniser for one asynchronous level.
`timescale 1ns/10ps
`default_nettype none
module pps_sync (
  // Clock and reset
  input  wire logic clk,
  input  wire logic arst_n,
  // Level in and out
  input  wire logic din,
  output var  logic dout
);
  logic meta_reg;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      meta_reg <= 1'b0;
      dout     <= 1'b0;
    end else begin
      meta_reg <= din;
      dout     <= meta_reg;
    end
  end
endmodule : pps_sync
`default_nettype wire

//--- pps_timer.sv
// Cycle counter that clears on state entry and flags expiry.
`timescale 1ns/10ps
`default_nettype none
module pps_timer #(
  parameter logic [16:0] LIMIT = 17'h0_2710
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic arst_n,
  // Control
  input  wire logic run,
  output var  logic expired
);
  logic [16:0] cnt_reg;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_reg <= 17'h0_0000;
      expired <= 1'b0;
    end else if (!run) begin
      cnt_reg <= 17'h0_0000;
      expired <= 1'b0;
    end else if (cnt_reg != LIMIT) begin
      cnt_reg <= cnt_reg + 17'h0_0001;
      expired <= (cnt_reg + 17'h0_0001) == LIMIT;
    end
  end
endmodule : pps_timer
`default_nettype wire

//--- pps_sequencer.sv
// Power-mode sequencer of a single-pair Ethernet PHY with an APB register slave.
// How it works
// - Normal never goes straight to Standby.
// - Received sleep-request codes move Normal into Sleep Request.
// - Sleep-request codes are sent only with autonomous control bit 0 set.
// - Incoming sleep-request codes count only with control-two bit 0 set.
// - Power mode bit 1 enters Sleep Request and starts code transmission.
// - Power mode bit 0 in Sleep Request forces Normal.
// - A frame before sleep-request timer expiry returns to Normal.
// - Sleep Request never goes straight to Standby.
// - Codes received plus timer expiry, or quiet cable, enter Silent.
// - Silent is entered only while wake input is low.
// - Silent to Standby when sleep disabled and silent timer expired.
// - Non-quiet codes before silent timer expiry move Silent to Standby.
// - Silent to Sleep on timer expiry or no activity anywhere.
// - Sleep-request timer starts at entry, one millisecond.
// - Silent timer lasts eight milliseconds; Sleep needs sleep enable.
// - Sleep disables everything but energy detect and wake; registers lost, no access.
// - Sleep is left on cable energy or wake high.
`timescale 1ns/10ps
`default_nettype none
module pps_sequencer (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        arst_n,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [13:0] paddr,
  input  wire logic [31:0] pwdata,
  output var  logic [31:0] prdata,
  output var  logic        pready,
  output var  logic        pslverr,
  // Cable and MAC indications from the PCS
  input  wire logic        sleep_request_codes_rx,
  input  wire logic        quiet_rx,
  input  wire logic        non_quiet_rx,
  input  wire logic        energy_det,
  input  wire logic        frame_seen,
  input  wire logic        activity,
  // Local wake pin
  input  wire logic        wake_pin,
  // Power state outputs
  output var  logic        sleep_request_codes_tx,
  output var  logic        send_quiet,
  output var  logic        pcs_pma_en,
  output var  logic        sleep_mode,
  output var  logic [4:0]  power_state
);

  // ----------------------------------------------------------------
  // Synchronised pin
  // ----------------------------------------------------------------
  logic wake_s;

  pps_sync u_wake_sync (
    .clk    (clk),
    .arst_n (arst_n),
    .din    (wake_pin),
    .dout   (wake_s)
  );

  // ----------------------------------------------------------------
  // State and registers
  // ----------------------------------------------------------------
  pps_pkg::pps_state_t state_reg;
  pps_pkg::pps_state_t state_next;
  logic [15:0] autonomous_control_reg;
  logic [15:0] power_mode_reg;
  logic [15:0] sleep_code_control_two_reg;
  logic [15:0] sleep_code_config_reg;
  logic        rq_run;
  logic        sil_run;
  logic        rq_expired;
  logic        sil_expired;
  logic        codes_ok;
  logic        wr_en;
  logic        rd_en;
  logic [11:0] word_idx;
  logic        mapped;
  logic        sleep_entry;

  assign word_idx = paddr[13:2];
  assign wr_en    = psel && penable && pwrite && pready;
  assign rd_en    = psel && !penable && !pwrite;
  assign mapped   = (word_idx == pps_pkg::AUTONOMOUS_CONTROL_IDX)
                 || (word_idx == pps_pkg::POWER_MODE_CONTROL_IDX)
                 || (word_idx == pps_pkg::SLEEP_CODE_CONTROL_TWO_IDX)
                 || (word_idx == pps_pkg::SLEEP_CODE_CONFIG_IDX)
                 || (word_idx == pps_pkg::STATE_STATUS_IDX);

  // Received codes only count when the PCS decoder is enabled.
  assign codes_ok = sleep_request_codes_rx
                 && sleep_code_control_two_reg[pps_pkg::CTRL2_RX_EN_BIT];

  assign sleep_entry = (state_next == pps_pkg::ST_SLEEP) && (state_reg != pps_pkg::ST_SLEEP);

  // ----------------------------------------------------------------
  // Timers
  // ----------------------------------------------------------------
  assign rq_run  = (state_reg == pps_pkg::ST_SLP_REQ) && (state_next == pps_pkg::ST_SLP_REQ);
  assign sil_run = (state_reg == pps_pkg::ST_SILENT) && (state_next == pps_pkg::ST_SILENT);

  pps_timer #(
    .LIMIT (17'(pps_pkg::SLEEP_RQST_CYCLES))
  ) u_rq_timer (
    .clk     (clk),
    .arst_n  (arst_n),
    .run     (rq_run),
    .expired (rq_expired)
  );

  pps_timer #(
    .LIMIT (17'(pps_pkg::SILENT_CYCLES))
  ) u_sil_timer (
    .clk     (clk),
    .arst_n  (arst_n),
    .run     (sil_run),
    .expired (sil_expired)
  );

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      pps_pkg::ST_STANDBY: begin
        if (energy_det || (wr_en && (word_idx == pps_pkg::POWER_MODE_CONTROL_IDX)
            && pwdata[pps_pkg::POWER_MODE_CONTROL_NORMAL_BIT])) begin
          state_next = pps_pkg::ST_NORMAL;
        end
      end
      pps_pkg::ST_NORMAL: begin
        // There is no path from here to Standby.
        if (codes_ok) begin
          state_next = pps_pkg::ST_SLP_REQ;
        end else if (wr_en && (word_idx == pps_pkg::POWER_MODE_CONTROL_IDX)
                     && pwdata[pps_pkg::POWER_MODE_CONTROL_SLEEP_BIT]) begin
          state_next = pps_pkg::ST_SLP_REQ;
        end
      end
      pps_pkg::ST_SLP_REQ: begin
        // Standby is never a target from Sleep Request.
        if (wr_en && (word_idx == pps_pkg::POWER_MODE_CONTROL_IDX)
            && pwdata[pps_pkg::POWER_MODE_CONTROL_NORMAL_BIT]) begin
          state_next = pps_pkg::ST_NORMAL;
        end else if (frame_seen && !rq_expired) begin
          state_next = pps_pkg::ST_NORMAL;
        end else if (!wake_s && ((codes_ok && rq_expired) || quiet_rx)) begin
          state_next = pps_pkg::ST_SILENT;
        end
      end
      pps_pkg::ST_SILENT: begin
        if (non_quiet_rx && !sil_expired) begin
          state_next = pps_pkg::ST_STANDBY;
        end else if (sil_expired
                     && !autonomous_control_reg[pps_pkg::AUTO_SLEEP_EN_BIT]) begin
          state_next = pps_pkg::ST_STANDBY;
        end else if (autonomous_control_reg[pps_pkg::AUTO_SLEEP_EN_BIT]
                     && (sil_expired || !activity)) begin
          state_next = pps_pkg::ST_SLEEP;
        end
      end
      pps_pkg::ST_SLEEP: begin
        if (energy_det || wake_s) begin
          state_next = pps_pkg::ST_STANDBY;
        end
      end
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= pps_pkg::ST_STANDBY;
    end else begin
      state_reg <= state_next;
    end
  end

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  // Entering Sleep wipes the configuration, as the whole digital core is unpowered there.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      autonomous_control_reg     <= pps_pkg::AUTO_RESET;
      power_mode_reg             <= pps_pkg::ZERO16;
      sleep_code_control_two_reg <= pps_pkg::ZERO16;
      sleep_code_config_reg      <= pps_pkg::ZERO16;
    end else if (sleep_entry || state_reg == pps_pkg::ST_SLEEP) begin
      autonomous_control_reg     <= pps_pkg::AUTO_RESET;
      power_mode_reg             <= pps_pkg::ZERO16;
      sleep_code_control_two_reg <= pps_pkg::ZERO16;
      sleep_code_config_reg      <= pps_pkg::ZERO16;
    end else if (wr_en) begin
      if (word_idx == pps_pkg::AUTONOMOUS_CONTROL_IDX) begin
        autonomous_control_reg <= pwdata[15:0];
      end
      if (word_idx == pps_pkg::POWER_MODE_CONTROL_IDX) begin
        power_mode_reg <= pwdata[15:0];
      end
      if (word_idx == pps_pkg::SLEEP_CODE_CONTROL_TWO_IDX) begin
        sleep_code_control_two_reg <= pwdata[15:0];
      end
      if (word_idx == pps_pkg::SLEEP_CODE_CONFIG_IDX) begin
        sleep_code_config_reg <= pwdata[15:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // APB answer
  // ----------------------------------------------------------------
  // No wait state: pready rises in the first access cycle.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      // Sleep refuses all management access.
      pslverr <= psel && !penable
                 && (!mapped || state_reg == pps_pkg::ST_SLEEP);
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      prdata <= pps_pkg::ZERO32;
    end else if (rd_en && state_reg != pps_pkg::ST_SLEEP) begin
      unique case (word_idx)
        pps_pkg::AUTONOMOUS_CONTROL_IDX:     prdata <= {16'h0000, autonomous_control_reg};
        pps_pkg::POWER_MODE_CONTROL_IDX:     prdata <= {16'h0000, power_mode_reg};
        pps_pkg::SLEEP_CODE_CONTROL_TWO_IDX: prdata <= {16'h0000, sleep_code_control_two_reg};
        pps_pkg::SLEEP_CODE_CONFIG_IDX:      prdata <= {16'h0000, sleep_code_config_reg};
        pps_pkg::STATE_STATUS_IDX:           prdata <= {27'h000_0000, state_reg};
        default:                             prdata <= pps_pkg::ZERO32;
      endcase
    end else if (rd_en) begin
      prdata <= pps_pkg::ZERO32;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sleep_request_codes_tx <= 1'b0;
      send_quiet             <= 1'b0;
      pcs_pma_en             <= 1'b0;
      sleep_mode             <= 1'b0;
      power_state            <= pps_pkg::ST_STANDBY;
    end else begin
      sleep_request_codes_tx <= (state_next == pps_pkg::ST_SLP_REQ)
                              && autonomous_control_reg[pps_pkg::AUTO_TX_EN_BIT];
      send_quiet             <= state_next == pps_pkg::ST_SILENT;
      pcs_pma_en             <= (state_next == pps_pkg::ST_NORMAL)
                              || (state_next == pps_pkg::ST_SLP_REQ);
      sleep_mode             <= state_next == pps_pkg::ST_SLEEP;
      power_state            <= state_next;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  chk_no_norm_stby: assert property (@(posedge clk) disable iff (!arst_n)
    state_reg == pps_pkg::ST_NORMAL |=> state_reg != pps_pkg::ST_STANDBY)
    else $error("Normal went straight to Standby.");

  chk_codes_enter: assert property (@(posedge clk) disable iff (!arst_n)
    (state_reg == pps_pkg::ST_NORMAL && codes_ok) |=> state_reg == pps_pkg::ST_SLP_REQ)
    else $error("Received codes did not enter Sleep Request.");

  chk_tx_gated: assert property (@(posedge clk) disable iff (!arst_n)
    sleep_request_codes_tx |-> $past(autonomous_control_reg[pps_pkg::AUTO_TX_EN_BIT]))
    else $error("Codes sent without transmit enable.");

  chk_rx_gated: assert property (@(posedge clk) disable iff (!arst_n)
    (state_reg == pps_pkg::ST_NORMAL && !sleep_code_control_two_reg[0]
     && !wr_en) |=> state_reg != pps_pkg::ST_SLP_REQ)
    else $error("Codes recognised while decoding disabled.");

  chk_force_normal: assert property (@(posedge clk) disable iff (!arst_n)
    (state_reg == pps_pkg::ST_SLP_REQ && wr_en && word_idx == pps_pkg::POWER_MODE_CONTROL_IDX
     && pwdata[0]) |=> state_reg == pps_pkg::ST_NORMAL ##1 pcs_pma_en)
    else $error("Normal force did not act.");

  chk_no_rq_stby: assert property (@(posedge clk) disable iff (!arst_n)
    state_reg == pps_pkg::ST_SLP_REQ |=> state_reg != pps_pkg::ST_STANDBY)
    else $error("Sleep Request went straight to Standby.");

  chk_wake_blocks: assert property (@(posedge clk) disable iff (!arst_n)
    (state_reg == pps_pkg::ST_SLP_REQ && wake_s) |=> state_reg != pps_pkg::ST_SILENT)
    else $error("Silent entered with wake high.");

  chk_sleep_leave: assert property (@(posedge clk) disable iff (!arst_n)
    (state_reg == pps_pkg::ST_SLEEP && energy_det) |=> state_reg == pps_pkg::ST_STANDBY
    ##1 !sleep_mode)
    else $error("Sleep not left on energy.");

  chk_rq_timeout: assert property (@(posedge clk) disable iff (!arst_n)
    $rose(state_reg == pps_pkg::ST_SLP_REQ) |-> !rq_expired [*8])
    else $error("Sleep-request timer expired too early.");

  chk_sw_enter: assert property (@(posedge clk) disable iff (!arst_n)
    (state_reg == pps_pkg::ST_NORMAL && wr_en && word_idx == pps_pkg::POWER_MODE_CONTROL_IDX
     && pwdata[pps_pkg::POWER_MODE_CONTROL_SLEEP_BIT]) |=> state_reg == pps_pkg::ST_SLP_REQ)
    else $error("Power mode write did not enter Sleep Request.");

  chk_frame_abort: assert property (@(posedge clk) disable iff (!arst_n)
    (state_reg == pps_pkg::ST_SLP_REQ && frame_seen && !rq_expired)
    |=> state_reg == pps_pkg::ST_NORMAL)
    else $error("Frame did not abandon Sleep Request.");

  chk_quiet_enter: assert property (@(posedge clk) disable iff (!arst_n)
    (state_reg == pps_pkg::ST_SLP_REQ && quiet_rx && !wake_s && !frame_seen && !wr_en)
    |=> state_reg == pps_pkg::ST_SILENT && send_quiet)
    else $error("Quiet cable did not enter Silent.");

  chk_busy_stby: assert property (@(posedge clk) disable iff (!arst_n)
    (state_reg == pps_pkg::ST_SILENT && non_quiet_rx && !sil_expired)
    |=> state_reg == pps_pkg::ST_STANDBY)
    else $error("Line activity in Silent did not reach Standby.");

  chk_idle_sleep: assert property (@(posedge clk) disable iff (!arst_n)
    (state_reg == pps_pkg::ST_SILENT && !non_quiet_rx && !activity
     && autonomous_control_reg[pps_pkg::AUTO_SLEEP_EN_BIT])
    |=> state_reg == pps_pkg::ST_SLEEP && sleep_mode)
    else $error("Idle Silent did not reach Sleep.");

  chk_sleep_wipe: assert property (@(posedge clk) disable iff (!arst_n)
    state_reg == pps_pkg::ST_SLEEP |-> autonomous_control_reg == pps_pkg::AUTO_RESET
    && power_mode_reg == pps_pkg::ZERO16 && sleep_code_control_two_reg == pps_pkg::ZERO16)
    else $error("Configuration kept in Sleep.");

  chk_sleep_refuse: assert property (@(posedge clk) disable iff (!arst_n)
    (psel && !penable && state_reg == pps_pkg::ST_SLEEP) |=> pready && pslverr)
    else $error("Access in Sleep was not refused.");

endmodule : pps_sequencer
`default_nettype wire

//--- pps_partner.sv
// Behavioural model of the remote link partner's sleep-request signalling.
`timescale 1ns/10ps
`default_nettype none
module pps_partner #(
  parameter int DELAY = 4
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic arst_n,
  // Line signal of the local device
  input  wire logic codes_tx,
  // Stimulus controls
  input  wire logic echo_en,
  input  wire logic ctl_codes,
  input  wire logic ctl_quiet,
  // Line indications towards the local device
  output var  logic codes_rx,
  output var  logic quiet_rx
);
  // ----------------------------------------------------------------
  // Echo of sleep-request codes
  // ----------------------------------------------------------------
  int cnt;

  // A real partner needs time to decode a request, so the echo lags by DELAY cycles.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt <= 0;
    end else if (codes_tx && echo_en) begin
      cnt <= (cnt < DELAY) ? cnt + 1 : cnt;
    end else begin
      cnt <= 0;
    end
  end

  assign codes_rx = ctl_codes || (cnt >= DELAY);
  assign quiet_rx = ctl_quiet;
endmodule : pps_partner
`default_nettype wire

//--- testbench.sv
// Self-checking testbench of the PHY power-state sequencer.
`timescale 1ns/10ps
`default_nettype none
module testbench;
  // ----------------------------------------------------------------
  // Signals and instances
  // ----------------------------------------------------------------
  localparam logic [11:0] AU = pps_pkg::AUTONOMOUS_CONTROL_IDX;
  localparam logic [11:0] PM = pps_pkg::POWER_MODE_CONTROL_IDX;
  localparam logic [11:0] C2 = pps_pkg::SLEEP_CODE_CONTROL_TWO_IDX;
  localparam logic [11:0] CF = pps_pkg::SLEEP_CODE_CONFIG_IDX;
  logic        clk, arst_n, psel, penable, pwrite, pready, pslverr, err;
  logic        quiet_rx, non_quiet_rx, energy_det, frame_seen, activity, wake_pin;
  logic        codes_rx, codes_tx, send_quiet, pcs_pma_en, sleep_mode;
  logic        echo_en, ctl_codes, ctl_quiet;
  logic [13:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [4:0]  power_state;
  int          n_mismatch, checks, cyc;

  pps_sequencer dut (.clk(clk), .arst_n(arst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sleep_request_codes_rx(codes_rx), .quiet_rx(quiet_rx),
    .non_quiet_rx(non_quiet_rx), .energy_det(energy_det), .frame_seen(frame_seen),
    .activity(activity), .wake_pin(wake_pin), .sleep_request_codes_tx(codes_tx),
    .send_quiet(send_quiet), .pcs_pma_en(pcs_pma_en), .sleep_mode(sleep_mode),
    .power_state(power_state));
  pps_partner #(.DELAY(4)) lp (.clk(clk), .arst_n(arst_n), .codes_tx(codes_tx),
    .echo_en(echo_en), .ctl_codes(ctl_codes), .ctl_quiet(ctl_quiet),
    .codes_rx(codes_rx), .quiet_rx(quiet_rx));

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : stop_test

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : chk

  task automatic st(input pps_pkg::pps_state_t e);
    chk({27'h0000000, power_state}, {27'h0000000, e}, "power state");
  endtask : st

  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask : settle

  // Holds the request until pready is sampled high; only the bench timeout ends a wait.
  task automatic apb(input logic w, input logic [11:0] i, input logic [15:0] d);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= {i, 2'b00};
    pwdata  <= {16'h0000, d};
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd      = prdata;
    err     = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    settle(0);
    st(pps_pkg::ST_STANDBY);
    apb(1'b0, AU, 16'h0000);
    chk(rd, 32'h0000_0002, "auto reset");
    apb(1'b0, C2, 16'h0000);
    chk(rd, 32'h0000_0000, "ctrl2 reset");
    apb(1'b0, 12'h001, 16'h0000);
    chk({31'h0, err}, 32'h0000_0001, "unmapped error");
    apb(1'b1, CF, 16'h0300);
    apb(1'b0, CF, 16'h0000);
    chk(rd, 32'h0000_0300, "config readback");
    $display("test reset done");
  endtask : t_reset

  task automatic t_normal();
    apb(1'b1, PM, 16'h0001);
    settle(0);
    st(pps_pkg::ST_NORMAL);
    @(posedge clk);
    {non_quiet_rx, energy_det, wake_pin, ctl_quiet} <= 4'hF;
    settle(5);
    st(pps_pkg::ST_NORMAL);
    @(posedge clk);
    {non_quiet_rx, energy_det, wake_pin, ctl_quiet} <= 4'h0;
    $display("test normal done");
  endtask : t_normal

  task automatic t_rx_codes();
    @(posedge clk);
    ctl_codes <= 1'b1;
    settle(3);
    st(pps_pkg::ST_NORMAL);
    apb(1'b1, C2, 16'h0001);
    settle(2);
    st(pps_pkg::ST_SLP_REQ);
    chk({31'h0, codes_tx}, 32'h0, "codes sent");
    @(posedge clk);
    ctl_codes    <= 1'b0;
    non_quiet_rx <= 1'b1;
    settle(3);
    st(pps_pkg::ST_SLP_REQ);
    @(posedge clk);
    non_quiet_rx <= 1'b0;
    apb(1'b1, PM, 16'h0001);
    settle(0);
    st(pps_pkg::ST_NORMAL);
    $display("test rx codes done");
  endtask : t_rx_codes

  task automatic t_sw_req();
    apb(1'b1, AU, 16'h0003);
    apb(1'b1, PM, 16'h0002);
    settle(0);
    st(pps_pkg::ST_SLP_REQ);
    chk({30'h0, codes_tx, pcs_pma_en}, 32'h3, "codes and pcs");
    @(posedge clk);
    frame_seen <= 1'b1;
    @(posedge clk);
    frame_seen <= 1'b0;
    settle(0);
    st(pps_pkg::ST_NORMAL);
    $display("test sw request done");
  endtask : t_sw_req

  task automatic t_quiet();
    apb(1'b1, AU, 16'h0001);
    // Wake must pass the synchroniser before the quiet cable is seen.
    wake_pin  <= 1'b1;
    apb(1'b1, PM, 16'h0002);
    @(posedge clk);
    ctl_quiet <= 1'b1;
    settle(5);
    st(pps_pkg::ST_SLP_REQ);
    @(posedge clk);
    wake_pin <= 1'b0;
    settle(5);
    st(pps_pkg::ST_SILENT);
    chk({31'h0, send_quiet}, 32'h1, "send quiet");
    @(posedge clk);
    ctl_quiet <= 1'b0;
    activity  <= 1'b0;
    settle(3);
    st(pps_pkg::ST_SILENT);
    @(posedge clk);
    activity     <= 1'b1;
    non_quiet_rx <= 1'b1;
    settle(1);
    st(pps_pkg::ST_STANDBY);
    @(posedge clk);
    non_quiet_rx <= 1'b0;
    $display("test quiet done");
  endtask : t_quiet

  task automatic t_timer();
    int n;
    apb(1'b1, AU, 16'h0003);
    apb(1'b1, PM, 16'h0001);
    echo_en <= 1'b1;
    apb(1'b1, PM, 16'h0002);
    settle(6000);
    st(pps_pkg::ST_SLP_REQ);
    @(posedge clk);
    frame_seen <= 1'b1;
    echo_en    <= 1'b0;
    @(posedge clk);
    frame_seen <= 1'b0;
    echo_en    <= 1'b1;
    apb(1'b1, PM, 16'h0002);
    settle(9980);
    st(pps_pkg::ST_SLP_REQ);
    n = 0;
    while (power_state !== pps_pkg::ST_SILENT && n < 40) begin
      settle(1);
      n++;
    end
    st(pps_pkg::ST_SILENT);
    chk(n, 32'd21, "request timer cycles");
    @(posedge clk);
    echo_en  <= 1'b0;
    activity <= 1'b0;
    settle(1);
    st(pps_pkg::ST_SLEEP);
    chk({30'h0, sleep_mode, pcs_pma_en}, 32'h2, "sleep outputs");
    apb(1'b0, AU, 16'h0000);
    chk({31'h0, err}, 32'h1, "access in sleep");
    @(posedge clk);
    energy_det <= 1'b1;
    @(posedge clk);
    energy_det <= 1'b0;
    settle(1);
    st(pps_pkg::ST_STANDBY);
    apb(1'b0, C2, 16'h0000);
    chk(rd, 32'h0000_0000, "ctrl2 lost");
    $display("test timer done");
  endtask : t_timer

  task automatic t_wake();
    apb(1'b1, PM, 16'h0001);
    apb(1'b1, PM, 16'h0002);
    @(posedge clk);
    ctl_quiet <= 1'b1;
    settle(1);
    @(posedge clk);
    ctl_quiet <= 1'b0;
    settle(1);
    st(pps_pkg::ST_SLEEP);
    @(posedge clk);
    activity <= 1'b1;
    wake_pin <= 1'b1;
    @(posedge clk);
    wake_pin <= 1'b0;
    settle(4);
    st(pps_pkg::ST_STANDBY);
    $display("test wake done");
  endtask : t_wake

  // ----------------------------------------------------------------
  // Clock, timeout and main sequence
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  always @(posedge clk) begin
    cyc++;
    if (cyc == 40000) begin
      n_mismatch++;
      stop_test();
    end
  end

  initial begin
    {psel, penable, pwrite, non_quiet_rx, energy_det, frame_seen, wake_pin} = 7'h00;
    {echo_en, ctl_codes, ctl_quiet, activity, arst_n} = 5'h02;
    paddr  = 14'h0000;
    pwdata = 32'h0000_0000;
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    t_reset();
    t_normal();
    t_rx_codes();
    t_sw_req();
    t_quiet();
    t_timer();
    t_wake();
    stop_test();
  end
endmodule : testbench
`default_nettype wire
